// ---- design/ppd_port_pad_drive_config.v ----
// top of the port pad drive configuration block: apb slave plus six
// pad cells. assumes apb on clk, single clock, port data from outside.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ppd_defs.vh"
module ppd_port_pad_drive_config
#(
    parameter NPINS = `PPD_NPINS
)
(
    input  wire                    clk,
    input  wire                    srst,
    input  wire                    clkEn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`PPD_ADDR_W-1:0]  paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    input  wire [NPINS-1:0]        portOut,   // data values, same clock
    output wire [NPINS-1:0]        padOut,
    output wire [NPINS-1:0]        padOe,
    output wire [NPINS-1:0]        pullUpEn,
    output wire [NPINS-1:0]        pullDnEn,
    output wire [NPINS-1:0]        trigOn
);
    reg  [NPINS-1:0]       dirQ;    // pin_direction_ctrl low half
    reg  [`PPD_TRIG_W-1:0] trigQ;   // trigger enables, pins 2..5
    reg  [NPINS-1:0]       odmQ;    // output_drain_mode_ctrl
    reg  [NPINS-1:0]       pselQ;   // pull_direction_select
    reg  [NPINS-1:0]       penQ;    // pull_device_enable
    reg  [31:0]            rdD;     // read mux result
    reg                    hitD;    // address decodes
    wire                   setup;   // setup phase seen
    wire                   wrEn;    // write commits this edge
    wire [NPINS-1:0]       trigFull; // trigger bits per pin

    // zero-wait answer: pready rises in the access cycle after setup
    assign setup = psel & ~penable;
    assign wrEn  = psel & penable & pready & pwrite & hitD;

    // pins 0 and 1 have no trigger control
    assign trigFull = {trigQ, 2'b00};

    // address decode and read mux; unused bits stay zero
    always @*
    begin
        rdD  = `PPD_ZERO32;
        hitD = 1'b1;
        case (paddr)
            `PPD_OFF_DIR:
            begin
                rdD[`PPD_DIR_LSB+NPINS-1:`PPD_DIR_LSB] = dirQ;
                rdD[`PPD_TRIG_MSB:`PPD_TRIG_LSB] = trigQ;
            end
            `PPD_OFF_ODM:  rdD[NPINS-1:0] = odmQ;
            `PPD_OFF_PSEL: rdD[NPINS-1:0] = pselQ;
            `PPD_OFF_PEN:  rdD[NPINS-1:0] = penQ;
            default:       hitD = 1'b0;
        endcase
    end

    // bus handshake: ready held one access cycle, error on bad address
    always @(posedge clk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PPD_ZERO32;
        end
        else if (clkEn)
        begin
            pready  <= setup;
            pslverr <= setup & ~hitD;
            if (setup && !pwrite)
                prdata <= rdD;
            else if (!psel)
                prdata <= `PPD_ZERO32;
        end
    end

    // register writes; only the defined bit fields are stored
    always @(posedge clk)
    begin
        if (srst)
        begin
            dirQ  <= `PPD_RST_DIR;
            trigQ <= `PPD_RST_TRIG;
            odmQ  <= `PPD_RST_ODM;
            pselQ <= `PPD_RST_PSEL;
            penQ  <= `PPD_RST_PEN;
        end
        else if (clkEn && wrEn)
        begin
            case (paddr)
                `PPD_OFF_DIR:
                begin
                    dirQ  <= pwdata[`PPD_DIR_LSB+NPINS-1:`PPD_DIR_LSB];
                    trigQ <= pwdata[`PPD_TRIG_MSB:`PPD_TRIG_LSB];
                end
                `PPD_OFF_ODM:  odmQ  <= pwdata[NPINS-1:0];
                `PPD_OFF_PSEL: pselQ <= pwdata[NPINS-1:0];
                `PPD_OFF_PEN:  penQ  <= pwdata[NPINS-1:0];
                default:       dirQ  <= dirQ;
            endcase
        end
    end

    // one pad cell per pin
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1)
        begin : gPin
            ppd_pad_cell uCell
            (
                .clk      (clk),
                .srst     (srst),
                .clkEn    (clkEn),
                .outVal   (portOut[i]),
                .dirOut   (dirQ[i]),
                .odMode   (odmQ[i]),
                .pullSel  (pselQ[i]),
                .pullEn   (penQ[i]),
                .trigEn   (trigFull[i]),
                .padOut   (padOut[i]),
                .padOe    (padOe[i]),
                .pullUpEn (pullUpEn[i]),
                .pullDnEn (pullDnEn[i]),
                .trigOn   (trigOn[i])
            );
        end
    endgenerate
endmodule

// ---- design/ppd_defs.vh ----
// constants for the port pad drive configuration block
// assumes a 32-bit apb slave and a six-pin port; included by bare name
//
// Contract
// - schmitt enables pins 2-5 at bits 18-21
// - open-drain bit per pin at 0008
// - open-drain pin drives low only, releases high
// - open-drain register resets to all zero
// - pull select per pin at 000C, 1=up
// - pull select resets to 003B
// - direction bit zero input, one output
// - pull applies only when enable bit set
`ifndef PPD_DEFS_VH
`define PPD_DEFS_VH

`define PPD_NPINS        6
`define PPD_ADDR_W       8
// register byte addresses
`define PPD_OFF_DIR      8'h04
`define PPD_OFF_ODM      8'h08
`define PPD_OFF_PSEL     8'h0C
`define PPD_OFF_PEN      8'h10
// field positions inside the direction word
`define PPD_DIR_LSB      0
`define PPD_TRIG_LSB     18
`define PPD_TRIG_MSB     21
`define PPD_TRIG_W       4
// reset values
`define PPD_RST_DIR      6'h00
`define PPD_RST_TRIG     4'h0
`define PPD_RST_ODM      6'h00
`define PPD_RST_PSEL     6'h3B
`define PPD_RST_PEN      6'h3F
`define PPD_ZERO32       32'h0000_0000

`endif

// ---- design/ppd_pad_cell.v ----
// one pin's pad control: turns register bits into pad drive controls
// assumes all inputs are registered in the clk domain
`timescale 1ns/1ps
module ppd_pad_cell
(
    input  wire clk,
    input  wire srst,
    input  wire clkEn,
    input  wire outVal,      // data value from the port data block
    input  wire dirOut,      // 1 = pin is output
    input  wire odMode,      // 1 = open-drain
    input  wire pullSel,     // 1 = pull-up, 0 = pull-down
    input  wire pullEn,      // 1 = pull device connected
    input  wire trigEn,      // schmitt enable request
    output reg  padOut,      // level driven onto the pad
    output reg  padOe,       // high while the pad is driven
    output reg  pullUpEn,    // pull-up device on
    output reg  pullDnEn,    // pull-down device on
    output reg  trigOn       // schmitt trigger on
);
    // registered pad controls so every top output comes from a flop
    always @(posedge clk)
    begin
        if (srst)
        begin
            padOut   <= 1'b0;
            padOe    <= 1'b0;
            pullUpEn <= 1'b0;
            pullDnEn <= 1'b0;
            trigOn   <= 1'b0;
        end
        else if (clkEn)
        begin
            padOut <= outVal;
            // input pins never drive; open-drain only drives a low
            if (!dirOut)
                padOe <= 1'b0;
            else if (odMode)
                padOe <= ~outVal;
            else
                padOe <= 1'b1;
            pullUpEn <= pullEn & pullSel;
            pullDnEn <= pullEn & ~pullSel;
            // trigger meaningful only while the pin is an output
            trigOn   <= trigEn & dirOut;
        end
    end
endmodule

// ---- tb/ppd_checker.sv ----
// checker: apb timing and pad relations of the pad config block
// assumes binding to the block top with clkEn held high
`timescale 1ns/1ps
module ppd_checker
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  portOut,
    input wire logic [5:0]  padOut,
    input wire logic [5:0]  pullUpEn,
    input wire logic [5:0]  pullDnEn,
    input wire logic [5:0]  trigOn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    trig_low_pins_a: assert property (trigOn[1:0] == 2'b00)
        else $error("trigger on pin 0 or 1");
    pull_exclusive_a: assert property ((pullUpEn & pullDnEn) == 6'h00)
        else $error("both pulls on");
    pad_data_copy_a: assert property (!$past(srst) |->
        padOut == $past(portOut)) else $error("pad data not copied");
    reserved_zero_a: assert property (pready && !pwrite &&
        (paddr == 8'h08 || paddr == 8'h0C) |-> prdata[31:6] == 26'h0)
        else $error("reserved bits set");
    pull_reset_a: assert property ($fell(srst) |=>
        pullUpEn == 6'h3B && pullDnEn == 6'h04) else $error("pull reset");
endmodule

// ---- tb/ppd_pad_model.sv ----
// pad model: resolves each pin level from the drive and pull controls
// assumes the block's registered pad outputs on the same clock
`timescale 1ns/1ps
module ppd_pad_model
(
    input  wire logic       clk,
    input  wire logic [5:0] padOut,
    input  wire logic [5:0] padOe,
    input  wire logic [5:0] pullUpEn,
    input  wire logic [5:0] pullDnEn,
    output logic      [5:0] pinLvl
);
    logic [5:0] wander_q = 6'h15; // floating pins change every cycle
    always @(posedge clk) wander_q <= ~wander_q;
    // released pins follow the pull, else they wander
    assign pinLvl = (padOe & padOut) | (~padOe & pullUpEn) |
        (~padOe & ~pullUpEn & ~pullDnEn & wander_q);
endmodule

// ---- tb/ppd_port_pad_drive_config_tb.sv ----
// testbench: apb register and pad drive checks for the pad config block
// assumes the pad model and checker are compiled before it
`timescale 1ns/1ps
module ppd_port_pad_drive_config_tb;
    logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr;
    logic [5:0]  portOut = 0, padOut, padOe, pullUpEn, pullDnEn;
    logic [5:0]  trigOn, pinLvl;
    int          mismatches = 0, compares = 0;
    initial forever #12.5 clk = ~clk;
    ppd_port_pad_drive_config ppd_port_pad_drive_config_inst (.clk(clk),
        .srst(srst), .clkEn(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .portOut(portOut),
        .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
        .pullDnEn(pullDnEn), .trigOn(trigOn));
    ppd_pad_model ppd_pad_model_inst (.clk(clk), .padOut(padOut),
        .padOe(padOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn),
        .pinLvl(pinLvl));
    task give_verdict;
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            mismatches++;
            $display("FAIL %0t got %h want %h", $time, g, x);
        end
    endtask
    // one apb transfer; waits for ready, keeps data and error
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk) n++; while (pready !== 1'b1 && n < 20);
        // a transfer that never gets its ready is a failure in itself
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("FAIL %0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_reset;
        apb(0, 8'h08, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_003B);
        apb(0, 8'h04, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 8'h10, 0);
        chk(rd, 32'h0000_003F);
        chk(pinLvl, 6'h3B);
    endtask
    task t_reserved;
        apb(1, 8'h08, 32'hFFFF_FFC3);
        apb(0, 8'h08, 0);
        chk(rd, 32'h0000_0003);
        apb(1, 8'h0C, 32'hFFFF_FFC4);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_0004);
        apb(1, 8'h20, 32'h0000_00FF);
        chk(err, 1'b1);
    endtask
    // mixed open-drain and push-pull outputs with pulls on released pins
    task t_drive;
        apb(1, 8'h08, 32'h0000_000F);
        apb(1, 8'h0C, 32'h0000_0002);
        portOut <= 6'h2A;
        // bits 16 and 17 are written too: pins 0 and 1 have no trigger
        apb(1, 8'h04, 32'h003F_003F);
        apb(0, 8'h04, 0);
        chk(rd, 32'h003C_003F);
        repeat (3) @(posedge clk);
        chk(padOut, 6'h2A);
        chk(padOe, 6'h35);
        chk(trigOn, 6'h3C);
        chk(pinLvl, 6'h22);
    endtask
    task t_input;
        apb(1, 8'h04, 32'h003C_0000);
        apb(1, 8'h10, 0);
        apb(0, 8'h04, 0);
        chk(rd, 32'h003C_0000);
        apb(0, 8'h10, 0);
        chk(rd, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(trigOn, 6'h00);
        chk(padOe, 6'h00);
        chk(pullUpEn | pullDnEn, 6'h00);
    endtask
    initial
    begin
        #100us;
        mismatches++;
        give_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_reserved;
        t_drive;
        t_input;
        give_verdict;
    end
endmodule
bind ppd_port_pad_drive_config ppd_checker ppd_checker_inst (.clk(clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portOut(portOut), .padOut(padOut), .pullUpEn(pullUpEn),
    .pullDnEn(pullDnEn), .trigOn(trigOn));
